// *** logic/isd_pkg.sv ***
/*
 * Constants shared by the interrupt-source encoder and serial clock divider.
 * Assumes 32-bit AHB-Lite data and single-word register accesses.
 */
package isd_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] ISD_OFF_MODE = 8'h00;
	localparam logic [7:0] ISD_OFF_STATUS = 8'h04;
	localparam logic [7:0] ISD_OFF_ENABLE = 8'h08;
	localparam logic [7:0] ISD_OFF_SOURCE = 8'h0C;
	localparam logic [7:0] ISD_OFF_PRESCALE = 8'h10;
	localparam logic [7:0] ISD_OFF_LOW = 8'h14;
	localparam logic [7:0] ISD_OFF_HIGH = 8'h18;
	localparam int ISD_ADDR_LSB = 2;
	localparam int ISD_ADDR_MSB = 7;

	// ****************************************
	// Events and source codes
	// ****************************************
	localparam int ISD_NEVT = 7;
	localparam logic [2:0] ISD_CODE_NONE = 3'h0;
	localparam logic [2:0] ISD_CODE_ARB = 3'h1;
	localparam logic [2:0] ISD_CODE_NACK = 3'h2;
	localparam logic [2:0] ISD_CODE_READY = 3'h3;
	localparam logic [2:0] ISD_CODE_RXRDY = 3'h4;
	localparam logic [2:0] ISD_CODE_TXRDY = 3'h5;
	localparam logic [2:0] ISD_CODE_STOP = 3'h6;
	localparam logic [2:0] ISD_CODE_SLAVE = 3'h7;
	// Flags that a source read also clears: arbitration, nack, stop
	localparam logic [6:0] ISD_READ_CLEARS = 7'h23;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int ISD_MODE_RUN = 0;
	localparam int ISD_MODE_MST = 1;
	localparam int ISD_SRC_RSV_LSB = 8;
	localparam int ISD_SRC_RSV_MSB = 11;
	localparam logic [1:0] ISD_MODE_RST = 2'h0;
	localparam logic [7:0] ISD_PSC_RST = 8'h00;
	localparam logic [15:0] ISD_LOW_RST = 16'h0009;
	localparam logic [15:0] ISD_HIGH_RST = 16'h0000;

	// ****************************************
	// Divider delay d and bus codes
	// ****************************************
	localparam logic [2:0] ISD_D_PSC0 = 3'h7;
	localparam logic [2:0] ISD_D_PSC1 = 3'h6;
	localparam logic [2:0] ISD_D_PSCN = 3'h5;
	localparam logic [7:0] ISD_PSC_ONE = 8'h01;
	localparam logic [1:0] ISD_HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] ISD_HTRANS_SEQ = 2'h3;

	function automatic logic [2:0] isd_delay(input logic [7:0] psc);
		if (psc == ISD_PSC_RST) begin
			return ISD_D_PSC0;
		end else if (psc == ISD_PSC_ONE) begin
			return ISD_D_PSC1;
		end
		return ISD_D_PSCN;
	endfunction : isd_delay

endpackage : isd_pkg

// *** logic/isd_scl_gen.sv ***
/*
 * Prescaler and master serial clock generator.
 * Assumes run, master and divider values come from registers on hclk.
 */
`timescale 1ns/1ps
module isd_scl_gen import isd_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic module_run,
	input wire logic master,
	input wire logic [7:0] prescale_div,
	input wire logic [15:0] low_phase_div,
	input wire logic [15:0] high_phase_div,
	output logic scl_oe,
	output logic core_rst_n
);

	typedef struct packed {
		logic run_q;
		logic [7:0] psc_act;
		logic [7:0] pcnt;
		logic phase_low;
		logic [16:0] hcnt;
		logic scl_oe;
		logic core_rst_n;
	} isd_gen_t;

	isd_gen_t s;
	isd_gen_t next_s;
	logic tick;
	logic [16:0] target;

	always_comb begin
		next_s = s;
		tick = (s.pcnt == s.psc_act);
		target = s.phase_low ? (17'(low_phase_div) + 17'(isd_delay(s.psc_act))) // RULE14 RULE18
			: (17'(high_phase_div) + 17'(isd_delay(s.psc_act))); // RULE16 RULE17
		next_s.run_q = module_run;
		if (!module_run) begin
			// Held in reset: no clock, no bus condition detection
			next_s.core_rst_n = 1'b0; // RULE19
			next_s.pcnt = '0;
			next_s.hcnt = '0;
			next_s.phase_low = 1'b1;
			next_s.scl_oe = 1'b0;
		end else if (!s.run_q) begin
			next_s.core_rst_n = 1'b1;
			next_s.psc_act = prescale_div; // RULE11
			next_s.pcnt = '0;
			next_s.hcnt = '0;
			next_s.phase_low = 1'b1;
		end else begin
			next_s.pcnt = tick ? '0 : s.pcnt + 8'h01; // RULE9
			if (!master) begin
				next_s.hcnt = '0;
				next_s.phase_low = 1'b1;
				next_s.scl_oe = 1'b0; // RULE13
			end else begin
				if (tick) begin
					if (s.hcnt + 17'h00001 >= target) begin
						next_s.hcnt = '0;
						next_s.phase_low = !s.phase_low;
					end else begin
						next_s.hcnt = s.hcnt + 17'h00001;
					end
				end
				next_s.scl_oe = next_s.phase_low; // RULE13
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '{run_q: 1'b0, psc_act: ISD_PSC_RST, pcnt: 8'h00, phase_low: 1'b1,
				hcnt: 17'h00000, scl_oe: 1'b0, core_rst_n: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign scl_oe = s.scl_oe;
	assign core_rst_n = s.core_rst_n;

	// ****************************************
	// Checks
	// ****************************************
	property p_psc_hold;
		@(posedge hclk) disable iff (!hresetn)
		s.run_q && module_run |=> s.psc_act == $past(s.psc_act);
	endproperty
	a_psc_hold: assert property (p_psc_hold) else $error("prescale changed while running"); // RULE11

	property p_mod_tick;
		@(posedge hclk) disable iff (!hresetn)
		s.run_q && module_run && tick ##1 module_run |-> s.pcnt == 8'h00;
	endproperty
	a_mod_tick: assert property (p_mod_tick) else $error("module clock divider not wrapping"); // RULE9

	property p_slave_quiet;
		@(posedge hclk) disable iff (!hresetn)
		!master |=> !s.scl_oe;
	endproperty
	a_slave_quiet: assert property (p_slave_quiet) else $error("clock driven while not master"); // RULE13

	property p_held;
		@(posedge hclk) disable iff (!hresetn)
		!module_run |=> !core_rst_n && !scl_oe;
	endproperty
	a_held: assert property (p_held) else $error("module active while run bit low"); // RULE19

	property p_phase_len;
		@(posedge hclk) disable iff (!hresetn)
		tick && s.run_q && module_run && master && s.hcnt + 17'h00001 < target
			|=> s.phase_low == $past(s.phase_low) || !module_run || !master;
	endproperty
	a_phase_len: assert property (p_phase_len) else $error("phase ended early"); // RULE14 RULE17

endmodule : isd_scl_gen

// *** logic/isd_top.sv ***
/*
 * Interrupt-source encoder, status flags and serial clock registers on AHB-Lite.
 * Assumes event pulses come from controller logic on hclk, one cycle each.
 */
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
// What this block does
// RULE1 - Source code 0 none, 1 arbitration lost, 2 nack, 3 registers ready.
// RULE2 - Codes 4 receive ready, 5 transmit ready, 6 stop seen, 7 addressed as slave.
// RULE3 - A processor read of the source register clears the code field.
// RULE4 - After clearing, a pending enabled lower-priority event's code is loaded.
// RULE5 - Reading code 1, 2 or 6 also clears that status flag.
// RULE6 - Emulator reads leave the code field and status flags untouched.
// RULE7 - Source bits 15-12, 7-3 and prescaler bits 15-8 read zero, ignore writes.
// RULE8 - Software writes zeros to source bits 11-8, which are read/write, reset zero.
// RULE9 - Module clock is input clock divided by prescale value plus one.
// RULE10 - Software programs the prescale value while the run bit is zero.
// RULE11 - Prescale value takes effect only when the run bit rises.
// RULE12 - Software should keep the module clock between 7 and 12 MHz.
// RULE13 - Serial clock is generated only as master, from low and high dividers.
// RULE14 - Low phase lasts module period times low divider plus d.
// RULE15 - Software keeps the low divider non-zero; it resets to 9.
// RULE16 - High phase length comes from its own 16-bit divider.
// RULE17 - High phase lasts module period times high divider plus d.
// RULE18 - d is 7 for prescale 0, 6 for 1, 5 above 1.
// RULE19 - With run bit zero the module is held in reset.
// RULE20 - Among pending enabled events, lowest code first.
`timescale 1ns/1ps
module isd_top import isd_pkg::*; (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic emu_access,
	input wire logic [6:0] event_set,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [6:0] status_flags,
	output logic scl_out,
	output logic scl_oe,
	output logic core_rst_n
);

	typedef struct packed {
		logic [1:0] mode;
		logic [6:0] status;
		logic [6:0] enable;
		logic [3:0] src_rsv;
		logic [2:0] irq_event_code;
		logic [2:0] floor;
		logic [7:0] psc;
		logic [15:0] low;
		logic [15:0] high;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] hrdata;
		logic scl_out;
	} isd_regs_t;

	isd_regs_t s;
	isd_regs_t next_s;
	logic take;
	logic rd_func;
	logic [6:0] pend;
	logic [2:0] pick;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [2:0] isd_pick(input logic [6:0] p, input logic [2:0] fl);
		logic [2:0] code;
		code = ISD_CODE_NONE;
		for (int i = ISD_NEVT - 1; i >= 0; i--) begin
			if (p[i] && 3'(i + 1) > fl) begin
				code = 3'(i + 1);
			end
		end
		return code;
	endfunction : isd_pick

	function automatic logic [31:0] isd_read(input isd_regs_t r, input logic [7:0] a);
		logic [31:0] d;
		d = 32'h00000000;
		unique case (a)
			ISD_OFF_MODE: d[1:0] = r.mode;
			ISD_OFF_STATUS: d[6:0] = r.status;
			ISD_OFF_ENABLE: d[6:0] = r.enable;
			ISD_OFF_SOURCE: d = {20'h00000, r.src_rsv, 5'h00, r.irq_event_code}; // RULE7 RULE8
			ISD_OFF_PRESCALE: d[7:0] = r.psc; // RULE7
			ISD_OFF_LOW: d[15:0] = r.low;
			ISD_OFF_HIGH: d[15:0] = r.high;
			default: d = 32'h00000000;
		endcase
		return d;
	endfunction : isd_read

	function automatic logic [7:0] isd_word(input logic [31:0] a);
		return {a[ISD_ADDR_MSB:ISD_ADDR_LSB], 2'h0};
	endfunction : isd_word

	// ****************************************
	// Register file and source encoder
	// ****************************************
	assign take = hsel && hready && (htrans == ISD_HTRANS_NONSEQ || htrans == ISD_HTRANS_SEQ);
	assign rd_func = take && !hwrite && !emu_access && isd_word(haddr) == ISD_OFF_SOURCE; // RULE6

	always_comb begin
		next_s = s;
		// Data phase of a write lands first, so a following read sees it
		if (s.wr_pend) begin
			unique case (s.wr_addr)
				ISD_OFF_MODE: next_s.mode = hwdata[1:0];
				ISD_OFF_STATUS: next_s.status = s.status & ~hwdata[6:0];
				ISD_OFF_ENABLE: next_s.enable = hwdata[6:0];
				ISD_OFF_SOURCE: next_s.src_rsv = hwdata[ISD_SRC_RSV_MSB:ISD_SRC_RSV_LSB]; // RULE8
				ISD_OFF_PRESCALE: next_s.psc = hwdata[7:0]; // RULE7
				ISD_OFF_LOW: next_s.low = hwdata[15:0];
				ISD_OFF_HIGH: next_s.high = hwdata[15:0];
				default: next_s.mode = next_s.mode;
			endcase
		end
		next_s.wr_pend = take && hwrite;
		next_s.wr_addr = isd_word(haddr);
		next_s.hrdata = (take && !hwrite) ? isd_read(next_s, isd_word(haddr)) : 32'h00000000;
		// Held module: controller flags stay cleared in reset
		if (!s.mode[ISD_MODE_RUN]) begin
			next_s.status = '0; // RULE19
		end
		if (rd_func) begin
			next_s.irq_event_code = ISD_CODE_NONE; // RULE3
			next_s.floor = s.irq_event_code;
			if (s.irq_event_code != ISD_CODE_NONE && ISD_READ_CLEARS[s.irq_event_code - 3'h1]) begin
				next_s.status[s.irq_event_code - 3'h1] = 1'b0; // RULE5
			end
		end
		// Set beats clear
		if (s.mode[ISD_MODE_RUN]) begin
			next_s.status = next_s.status | event_set;
		end
		pend = s.status & s.enable;
		pick = isd_pick(pend, s.floor); // RULE20
		if (!rd_func && s.irq_event_code == ISD_CODE_NONE) begin
			next_s.irq_event_code = pick; // RULE1 RULE2 RULE4
			if (pick == ISD_CODE_NONE) begin
				next_s.floor = ISD_CODE_NONE;
			end
		end
		next_s.scl_out = 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= '{mode: ISD_MODE_RST, status: 7'h00, enable: 7'h00, src_rsv: 4'h0,
				irq_event_code: ISD_CODE_NONE, floor: ISD_CODE_NONE, psc: ISD_PSC_RST,
				low: ISD_LOW_RST, high: ISD_HIGH_RST, wr_pend: 1'b0, wr_addr: 8'h00,
				hrdata: 32'h00000000, scl_out: 1'b0};
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			s <= next_s;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	assign hrdata = s.hrdata;
	assign status_flags = s.status;
	assign scl_out = s.scl_out;

	// ****************************************
	// Clock chain
	// ****************************************
	isd_scl_gen u_gen (
		.hclk(hclk),
		.hresetn(hresetn),
		.module_run(s.mode[ISD_MODE_RUN]),
		.master(s.mode[ISD_MODE_MST]),
		.prescale_div(s.psc),
		.low_phase_div(s.low),
		.high_phase_div(s.high),
		.scl_oe(scl_oe),
		.core_rst_n(core_rst_n)
	);

	// ****************************************
	// Checks
	// ****************************************
	property p_read_clears;
		@(posedge hclk) disable iff (!hresetn)
		rd_func |=> s.irq_event_code == ISD_CODE_NONE;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("source read did not clear code"); // RULE3

	property p_read_flag;
		@(posedge hclk) disable iff (!hresetn)
		rd_func && s.irq_event_code == ISD_CODE_ARB && !event_set[0] |=> !s.status[0];
	endproperty
	a_read_flag: assert property (p_read_flag) else $error("arbitration flag not cleared"); // RULE5

	property p_read_stop;
		@(posedge hclk) disable iff (!hresetn)
		rd_func && s.irq_event_code == ISD_CODE_STOP && !event_set[5] |=> !s.status[5];
	endproperty
	a_read_stop: assert property (p_read_stop) else $error("stop flag not cleared"); // RULE5

	property p_read_nack;
		@(posedge hclk) disable iff (!hresetn)
		rd_func && s.irq_event_code == ISD_CODE_NACK && !event_set[1] |=> !s.status[1];
	endproperty
	a_read_nack: assert property (p_read_nack) else $error("nack flag not cleared"); // RULE5

	property p_emu_flags;
		@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && emu_access && s.mode[ISD_MODE_RUN] && !s.wr_pend
			|=> s.status == ($past(s.status) | $past(event_set));
	endproperty
	a_emu_flags: assert property (p_emu_flags) else $error("emulator read changed flags"); // RULE6

	property p_emu_read;
		@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && emu_access && s.irq_event_code != ISD_CODE_NONE
			|=> s.irq_event_code == $past(s.irq_event_code);
	endproperty
	a_emu_read: assert property (p_emu_read) else $error("emulator read changed code"); // RULE6

	property p_src_rsv;
		@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && isd_word(haddr) == ISD_OFF_SOURCE
			|=> hrdata[31:12] == 20'h00000 && hrdata[7:3] == 5'h00;
	endproperty
	a_src_rsv: assert property (p_src_rsv) else $error("source reserved bits nonzero"); // RULE7

	property p_psc_rsv;
		@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && isd_word(haddr) == ISD_OFF_PRESCALE
			|=> hrdata[31:8] == 24'h000000;
	endproperty
	a_psc_rsv: assert property (p_psc_rsv) else $error("prescale reserved bits nonzero"); // RULE7

	property p_load_pending;
		@(posedge hclk) disable iff (!hresetn)
		s.irq_event_code == ISD_CODE_NONE && !rd_func ##1 s.irq_event_code != ISD_CODE_NONE
			|-> ($past(pend) & (7'h01 << (s.irq_event_code - 3'h1))) != 7'h00
			&& $past(s.floor) < s.irq_event_code;
	endproperty
	a_load_pending: assert property (p_load_pending) else $error("loaded code not pending"); // RULE4

	property p_priority;
		@(posedge hclk) disable iff (!hresetn)
		s.irq_event_code == ISD_CODE_NONE && !rd_func && s.floor == ISD_CODE_NONE && pend[0]
			|=> s.irq_event_code == ISD_CODE_ARB;
	endproperty
	a_priority: assert property (p_priority) else $error("arbitration lost not first"); // RULE20

	property p_set_wins;
		@(posedge hclk) disable iff (!hresetn)
		s.mode[ISD_MODE_RUN] && event_set[1] |=> s.status[1];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost against clear"); // RULE1

endmodule : isd_top

// *** testbench/isd_bus_peer.sv ***
/*
 * Two-wire bus peer: pull-up on the serial clock line and a phase length monitor.
 * Assumes scl_oe high means the block drives scl_out onto the clock line.
 */
`timescale 1ns/1ps
module isd_bus_peer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic scl_oe,
	input wire logic scl_out,
	output logic scl_line,
	output logic [31:0] low_len,
	output logic [31:0] high_len,
	output logic [31:0] falls
);
	logic [31:0] run_len;
	logic prev;

	// Released line floats high through the pull-up
	assign scl_line = scl_oe ? scl_out : 1'b1;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_len <= 32'h0;
			prev <= 1'b1;
			low_len <= 32'h0;
			high_len <= 32'h0;
			falls <= 32'h0;
		end else begin
			prev <= scl_line;
			if (scl_line != prev) begin
				run_len <= 32'h1;
				if (prev) begin
					high_len <= run_len;
					falls <= falls + 32'h1;
				end else begin
					low_len <= run_len;
				end
			end else begin
				run_len <= run_len + 32'h1;
			end
		end
	end
endmodule : isd_bus_peer

// *** testbench/isd_top_test.sv ***
/*
 * Self-checking bench for the source encoder and serial clock divider.
 * Assumes a single AHB-Lite slave, so hready is the block's own hreadyout.
 */
`timescale 1ns/1ps
module isd_top_test import isd_pkg::*;;
	logic hclk, hresetn, hsel, hwrite, emu_access;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [6:0] event_set, status_flags;
	logic hreadyout, hresp, scl_out, scl_oe, core_rst_n, scl_line;
	logic [31:0] low_len, high_len, falls;
	int bad_count, total_checks;

	isd_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.emu_access(emu_access), .event_set(event_set), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .status_flags(status_flags),
		.scl_out(scl_out), .scl_oe(scl_oe), .core_rst_n(core_rst_n));

	isd_bus_peer peer (.hclk(hclk), .hresetn(hresetn), .scl_oe(scl_oe), .scl_out(scl_out),
		.scl_line(scl_line),
		.low_len(low_len), .high_len(high_len), .falls(falls));

	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end

	// ****************************************
	// Bus and compare tasks
	// ****************************************
	task end_of_test;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test

	task give_up;
		bad_count++;
		$display("unexpected wait: expected done seen timeout");
		end_of_test;
	endtask : give_up

	task check(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : check

	task wait_ready;
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 50) give_up;
			@(posedge hclk);
		end
	endtask : wait_ready

	task xfer(input logic w, input logic emu, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= ISD_HTRANS_NONSEQ;
		hwrite <= w;
		emu_access <= emu;
		wait_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		emu_access <= 1'b0;
		hwdata <= d;
		wait_ready;
		rd = hrdata;
	endtask : xfer

	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, 1'b0, a, d);
	endtask : wr

	task rdchk(input string what, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, 1'b0, a, 32'h0);
		check(what, e, rd);
		check("response", 32'h0, {31'h0, hresp});
	endtask : rdchk

	task pulse(input logic [6:0] v);
		@(posedge hclk);
		event_set <= v;
		@(posedge hclk);
		event_set <= 7'h00;
		repeat (3) @(posedge hclk);
	endtask : pulse

	// ****************************************
	// Scenarios
	// ****************************************
	task t_regs;
		rdchk("low reset", ISD_OFF_LOW, 32'h9);
		rdchk("high reset", ISD_OFF_HIGH, 32'h0);
		rdchk("unmapped", 8'h1C, 32'h0);
		wr(ISD_OFF_SOURCE, 32'hFFFFFFFF);
		rdchk("source rw bits", ISD_OFF_SOURCE, 32'h00000F00);
		wr(ISD_OFF_SOURCE, 32'h0);
		rdchk("source zero", ISD_OFF_SOURCE, 32'h0);
		wr(ISD_OFF_PRESCALE, 32'hFFFF);
		rdchk("prescale bits", ISD_OFF_PRESCALE, 32'h00FF);
		$display("test registers done");
	endtask : t_regs

	task t_codes;
		wr(ISD_OFF_MODE, 32'h1);
		wr(ISD_OFF_ENABLE, 32'h7F);
		for (int i = 0; i < 7; i++) begin
			pulse(7'h01 << i);
			rdchk("code", ISD_OFF_SOURCE, i + 1);
			check("flags", {25'h0, ISD_READ_CLEARS[i] ? 7'h00 : 7'h01 << i},
				{25'h0, status_flags});
			wr(ISD_OFF_STATUS, 32'h1 << i);
			xfer(1'b0, 1'b0, ISD_OFF_SOURCE, 32'h0);
			rdchk("code none", ISD_OFF_SOURCE, 32'h0);
		end
		pulse(7'h41);
		rdchk("first code", ISD_OFF_SOURCE, 32'h1);
		check("flags", 32'h40, {25'h0, status_flags});
		rdchk("next code", ISD_OFF_SOURCE, 32'h7);
		wr(ISD_OFF_ENABLE, 32'h04);
		wr(ISD_OFF_STATUS, 32'h7F);
		xfer(1'b0, 1'b0, ISD_OFF_SOURCE, 32'h0);
		check("reloaded code", 32'h7, rd);
		pulse(7'h06);
		rdchk("enabled code", ISD_OFF_SOURCE, 32'h3);
		wr(ISD_OFF_STATUS, 32'h7F);
		xfer(1'b0, 1'b0, ISD_OFF_SOURCE, 32'h0);
		rdchk("stays none", ISD_OFF_SOURCE, 32'h0);
		wr(ISD_OFF_ENABLE, 32'h7F);
		pulse(7'h02);
		xfer(1'b0, 1'b1, ISD_OFF_SOURCE, 32'h0);
		check("emu code", 32'h2, rd);
		xfer(1'b0, 1'b1, ISD_OFF_SOURCE, 32'h0);
		check("emu code again", 32'h2, rd);
		check("emu flags", 32'h02, {25'h0, status_flags});
		rdchk("cpu code", ISD_OFF_SOURCE, 32'h2);
		check("cpu flags", 32'h0, {25'h0, status_flags});
		$display("test source codes done");
	endtask : t_codes

	task wait_scl(input int psc);
		int n, d, base;
		n = 0;
		d = (psc == 0) ? 7 : (psc == 1) ? 6 : 5;
		base = int'(falls);
		while (int'(falls) < base + 3) begin
			n++;
			if (n > 3000) give_up;
			@(posedge hclk);
		end
		check("low phase", (3 + d) * (psc + 1), low_len);
		check("high phase", (2 + d) * (psc + 1), high_len);
		check("core run", 32'h1, {31'h0, core_rst_n});
	endtask : wait_scl

	task t_clock;
		logic [7:0] pl [4];
		pl = '{8'h00, 8'h01, 8'h02, 8'h13};
		for (int k = 0; k < 4; k++) begin
			wr(ISD_OFF_MODE, 32'h0);
			wr(ISD_OFF_PRESCALE, {24'h0, pl[k]});
			wr(ISD_OFF_LOW, 32'h3);
			wr(ISD_OFF_HIGH, 32'h2);
			wr(ISD_OFF_MODE, 32'h3);
			wait_scl(pl[k]);
		end
		wr(ISD_OFF_PRESCALE, 32'h0);
		wait_scl(19);
		wr(ISD_OFF_MODE, 32'h1);
		repeat (700) @(posedge hclk);
		rd = falls;
		repeat (700) @(posedge hclk);
		check("no master clock", rd, falls);
		check("line released", 32'h1, {31'h0, scl_line});
		wr(ISD_OFF_MODE, 32'h0);
		pulse(7'h01);
		check("held in reset", 32'h0, {31'h0, core_rst_n});
		check("event ignored", 32'h0, {25'h0, status_flags});
		$display("test serial clock done");
	endtask : t_clock

	initial begin
		bad_count = 0;
		total_checks = 0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		emu_access = 1'b0;
		event_set = 7'h00;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_regs;
		t_codes;
		t_clock;
		end_of_test;
	end
endmodule : isd_top_test
